// [tpt_params.svh]
`ifndef TPT_PARAMS_SVH
`define TPT_PARAMS_SVH

`define TPT_OFS_CTRL 8'h00
`define TPT_OFS_SIZE 8'h04
`define TPT_OFS_HPAR 8'h08
`define TPT_OFS_VPAR 8'h0C
`define TPT_OFS_STAT 8'h10

`define TPT_CTRL_EN 0
`define TPT_CTRL_HPOL 1
`define TPT_CTRL_VPOL 2
`define TPT_CTRL_CKINV 3
`define TPT_CTRL_PH_LO 4
`define TPT_CTRL_DIV_LO 8

`define TPT_SIZE_W_LO 0
`define TPT_SIZE_H_LO 16
`define TPT_PAR_SW_LO 0
`define TPT_PAR_BP_LO 10
`define TPT_PAR_FP_LO 20

`define TPT_STAT_UNDER 0
`define TPT_STAT_VREG_LO 4
`define TPT_STAT_LINE_LO 16

`define TPT_CTRL_RST 32'h0000_0400
`define TPT_SIZE_RST 32'h0010_0020
`define TPT_HPAR_RST 32'h0040_1002
`define TPT_VPAR_RST 32'h0040_1002

`define TPT_CLK_PERIOD_PS 10000
`define TPT_PCP_MIN_PS 7500
`define TPT_PLAT_RATIO 3

`endif

// [tpt_pkg.sv]
package tpt_pkg;
	typedef enum logic [1:0] {
		TPT_SYNC = 2'b00,
		TPT_BACK = 2'b01,
		TPT_ACTIVE = 2'b10,
		TPT_FRONT = 2'b11
	} tpt_region_t;
endpackage : tpt_pkg

// [tpt_timing_gen.sv]
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
// Operation
// - Launch outputs on internal pixel clock rise.
// - Forwarded panel clock matches internal polarity; CKINV set inverts it.
// - Software selects sync polarity, default high.
// - Data valid is always active high.
// - Line is sync, back, active, front.
// - Frame is same four counts in lines.
// - Counts come from size and sync registers.
// - Pixel period never below minimum period.
// - Pixel clock at most third of platform.
// - Divider control selects clock edge and phase.
`include "tpt_params.svh"

module tpt_timing_gen
	import tpt_pkg::*;
#(
	parameter int PIX_W = 24,
	parameter int CNT_W = 10,
	parameter int LINE_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pixValid,
	output logic pixReady,
	input wire logic [PIX_W-1:0] pixData,
	output logic lineSyncOut,
	output logic frameSyncOut,
	output logic dataValidOut,
	output logic [PIX_W-1:0] pixelDataOut,
	output logic panelPixelClockOut
);

	// The pixel period may not fall below the panel minimum, nor the
	// pixel rate exceed a third of the platform clock.
	localparam int MIN_BY_PCP =
		(`TPT_PCP_MIN_PS + `TPT_CLK_PERIOD_PS - 1) / `TPT_CLK_PERIOD_PS;
	localparam int DIV_MIN_I = (MIN_BY_PCP > `TPT_PLAT_RATIO) ?
		MIN_BY_PCP : `TPT_PLAT_RATIO;
	localparam logic [7:0] DIV_MIN = 8'(DIV_MIN_I);

	logic [31:0] ctrl_ff;
	logic [31:0] size_ff;
	logic [31:0] hpar_ff;
	logic [31:0] vpar_ff;
	logic [31:0] prdata_ff;
	logic underrun_ff;
	logic [7:0] divCnt_ff;
	logic clkBase_ff;
	logic [3:0] clkDly_ff;
	logic panelClk_ff;
	logic lineSync_ff;
	logic frameSync_ff;
	logic dataValid_ff;
	logic [PIX_W-1:0] pixOut_ff;
	logic [PIX_W-1:0] buf_ff [2];
	logic wrPtr_ff;
	logic rdPtr_ff;
	logic [1:0] bufCnt_ff;

	logic enable;
	logic [7:0] divReq;
	logic [7:0] divEff;
	logic [7:0] nxt_divCnt;
	logic tick;
	logic setup;
	logic wrAcc;
	logic mapped;
	logic [31:0] rdMux;
	logic bufPush;
	logic bufPop;
	logic bufValid;
	logic activeNow;
	logic lineEnd;
	logic [LINE_W-1:0] lenTab [2][4];
	tpt_region_t region_ff [2];
	logic [LINE_W-1:0] cnt_ff [2];
	logic [1:0] step;
	logic [1:0] last;

	assign enable = ctrl_ff[`TPT_CTRL_EN];
	assign divReq = ctrl_ff[`TPT_CTRL_DIV_LO +: 8];

	// Divider floor bounds the pixel period.
	// Divider never below three platform cycles.
	assign divEff = (divReq < DIV_MIN) ? DIV_MIN : divReq;

	// APB slave: prdata is captured in the setup cycle so that the
	// access cycle can answer at once with no wait state.
	assign setup = psel && !penable;
	assign wrAcc = psel && penable && pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_ff;

	always_comb begin
		mapped = 1'b1;
		rdMux = 32'h0000_0000;
		case (paddr)
			`TPT_OFS_CTRL: rdMux = ctrl_ff;
			`TPT_OFS_SIZE: rdMux = size_ff;
			`TPT_OFS_HPAR: rdMux = hpar_ff;
			`TPT_OFS_VPAR: rdMux = vpar_ff;
			`TPT_OFS_STAT: begin
				rdMux[`TPT_STAT_UNDER] = underrun_ff;
				rdMux[`TPT_STAT_VREG_LO +: 2] = region_ff[1];
				rdMux[`TPT_STAT_LINE_LO +: LINE_W] = cnt_ff[1];
			end
			default: mapped = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rdMux;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= `TPT_CTRL_RST;
			size_ff <= `TPT_SIZE_RST;
			hpar_ff <= `TPT_HPAR_RST;
			vpar_ff <= `TPT_VPAR_RST;
		end else if (wrAcc) begin
			case (paddr)
				`TPT_OFS_CTRL: ctrl_ff <= pwdata;
				`TPT_OFS_SIZE: size_ff <= pwdata;
				`TPT_OFS_HPAR: hpar_ff <= pwdata;
				`TPT_OFS_VPAR: vpar_ff <= pwdata;
				default: ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	// Underrun is sticky; a new event beats a same-cycle clear.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			underrun_ff <= 1'b0;
		end else if (activeNow && tick && !bufValid) begin
			underrun_ff <= 1'b1;
		end else if (wrAcc && paddr == `TPT_OFS_STAT &&
				pwdata[`TPT_STAT_UNDER]) begin
			underrun_ff <= 1'b0;
		end
	end

	// Pixel clock divider; tick marks the internal pixel clock rise.
	assign tick = enable && (divCnt_ff == divEff - 8'h01);
	assign nxt_divCnt = (!enable || tick) ? 8'h00 : divCnt_ff + 8'h01;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt_ff <= 8'h00;
		end else begin
			divCnt_ff <= nxt_divCnt;
		end
	end

	// Panel clock base rises with the internal pixel clock.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clkBase_ff <= 1'b0;
		end else begin
			clkBase_ff <= enable && (nxt_divCnt < (divEff >> 1));
		end
	end

	// Divider control picks edge and phase delay.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clkDly_ff <= 4'h0;
			panelClk_ff <= 1'b0;
		end else begin
			clkDly_ff <= {clkDly_ff[2:0], clkBase_ff};
			panelClk_ff <= clkDly_ff[ctrl_ff[`TPT_CTRL_PH_LO +: 2]] ^
				ctrl_ff[`TPT_CTRL_CKINV];
		end
	end

	assign panelPixelClockOut = panelClk_ff;

	// Region lengths per axis; a zero count behaves as one.
	assign lenTab[0][0] = LINE_W'(hpar_ff[`TPT_PAR_SW_LO +: CNT_W]);
	assign lenTab[0][1] = LINE_W'(hpar_ff[`TPT_PAR_BP_LO +: CNT_W]);
	assign lenTab[0][2] = size_ff[`TPT_SIZE_W_LO +: LINE_W];
	assign lenTab[0][3] = LINE_W'(hpar_ff[`TPT_PAR_FP_LO +: CNT_W]);
	assign lenTab[1][0] = LINE_W'(vpar_ff[`TPT_PAR_SW_LO +: CNT_W]);
	assign lenTab[1][1] = LINE_W'(vpar_ff[`TPT_PAR_BP_LO +: CNT_W]);
	assign lenTab[1][2] = size_ff[`TPT_SIZE_H_LO +: LINE_W];
	assign lenTab[1][3] = LINE_W'(vpar_ff[`TPT_PAR_FP_LO +: CNT_W]);

	// Horizontal axis steps on every pixel; vertical at line end.
	assign step[0] = tick;
	assign lineEnd = tick && region_ff[0] == TPT_FRONT && last[0];
	assign step[1] = lineEnd;

	genvar ax;
	generate
		for (ax = 0; ax < 2; ax++) begin : g_axis
			assign last[ax] =
				(cnt_ff[ax] + LINE_W'(1)) >= lenTab[ax][region_ff[ax]];

			// Line period is sum of four counts.
			// Frame period counted in whole lines.
			// Regions advance sync, back, active, front.
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					region_ff[ax] <= TPT_SYNC;
					cnt_ff[ax] <= '0;
				end else if (!enable) begin
					region_ff[ax] <= TPT_SYNC;
					cnt_ff[ax] <= '0;
				end else if (step[ax]) begin
					if (last[ax]) begin
						cnt_ff[ax] <= '0;
						case (region_ff[ax])
							TPT_SYNC: region_ff[ax] <= TPT_BACK;
							TPT_BACK: region_ff[ax] <= TPT_ACTIVE;
							TPT_ACTIVE: region_ff[ax] <= TPT_FRONT;
							TPT_FRONT: region_ff[ax] <= TPT_SYNC;
							default: region_ff[ax] <= TPT_SYNC;
						endcase
					end else begin
						cnt_ff[ax] <= cnt_ff[ax] + LINE_W'(1);
					end
				end
			end
		end
	endgenerate

	assign activeNow = enable && region_ff[0] == TPT_ACTIVE &&
		region_ff[1] == TPT_ACTIVE;

	// Two-entry buffer between pixel source and panel; the source
	// stalls on pixReady, so a slow pixel clock loses no word.
	assign bufValid = bufCnt_ff != 2'd0;
	assign pixReady = bufCnt_ff != 2'd2;
	assign bufPush = pixValid && pixReady;
	assign bufPop = activeNow && tick && bufValid;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_ff <= 1'b0;
			rdPtr_ff <= 1'b0;
			bufCnt_ff <= 2'd0;
		end else begin
			if (bufPush) begin
				wrPtr_ff <= !wrPtr_ff;
			end
			if (bufPop) begin
				rdPtr_ff <= !rdPtr_ff;
			end
			bufCnt_ff <= bufCnt_ff + 2'(bufPush) - 2'(bufPop);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (bufPush) begin
			buf_ff[wrPtr_ff] <= pixData;
		end
	end

	// While enabled, outputs update only at pixel clock rise.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lineSync_ff <= 1'b0;
			frameSync_ff <= 1'b0;
			dataValid_ff <= 1'b0;
			pixOut_ff <= '0;
		end else if (!enable) begin
			lineSync_ff <= ctrl_ff[`TPT_CTRL_HPOL];
			frameSync_ff <= ctrl_ff[`TPT_CTRL_VPOL];
			dataValid_ff <= 1'b0;
			pixOut_ff <= '0;
		end else if (tick) begin
			lineSync_ff <= (region_ff[0] == TPT_SYNC) ^
				ctrl_ff[`TPT_CTRL_HPOL];
			frameSync_ff <= (region_ff[1] == TPT_SYNC) ^
				ctrl_ff[`TPT_CTRL_VPOL];
			dataValid_ff <= activeNow;
			pixOut_ff <= bufPop ? buf_ff[rdPtr_ff] : '0;
		end
	end

	assign lineSyncOut = lineSync_ff;
	assign frameSyncOut = frameSync_ff;
	assign dataValidOut = dataValid_ff;
	assign pixelDataOut = pixOut_ff;

endmodule : tpt_timing_gen

// [tpt_timing_gen_assertions.sv]
`timescale 1ns/1ps
module tpt_timing_gen_assertions #(
	parameter int PIX_W = 24
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic lineSyncOut,
	input wire logic frameSyncOut,
	input wire logic dataValidOut,
	input wire logic [PIX_W-1:0] pixelDataOut,
	input wire logic panelPixelClockOut
);
	// Control is snooped off the bus, so a settle window hides the retiming.
	logic [5:0] ctrl_ff;
	logic [4:0] settle_ff;
	logic acc;
	logic ctlWr;
	logic calm;
	assign acc = psel && penable;
	assign ctlWr = acc && pwrite && paddr == 8'h00;
	assign calm = settle_ff == 5'h00 && ctrl_ff[0];
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= 6'h00;
		end else if (ctlWr) begin
			ctrl_ff <= pwdata[5:0];
		end
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			settle_ff <= 5'h00;
		end else if (ctlWr) begin
			settle_ff <= 5'h1F;
		end else if (settle_ff != 5'h00) begin
			settle_ff <= settle_ff - 5'h01;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	chk_ready_high: assert property (
		acc |-> pready) else $error("access without ready");
	chk_unmapped_err: assert property (
		acc && !pwrite && (paddr > 8'h10 || paddr[1:0] != 2'h0)
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	chk_mapped_ok: assert property (
		acc && paddr <= 8'h10 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	chk_valid_line: assert property (
		calm && dataValidOut |-> lineSyncOut == ctrl_ff[1])
		else $error("valid during line sync");
	chk_valid_frame: assert property (
		calm && dataValidOut |-> frameSyncOut == ctrl_ff[2])
		else $error("valid during frame sync");
	chk_blank_zero: assert property (
		!dataValidOut |-> pixelDataOut == '0)
		else $error("data outside active area");
	chk_tick_span: assert property (
		calm && $changed({lineSyncOut, frameSyncOut, dataValidOut})
		|=> $stable({lineSyncOut, frameSyncOut, dataValidOut}) [*2])
		else $error("pixel period below three cycles");
	chk_clk_phase: assert property (
		calm && ctrl_ff[5:3] == 3'h0 && $changed(dataValidOut)
		|-> ##2 $rose(panelPixelClockOut))
		else $error("panel clock edge misplaced");
	chk_clk_shift: assert property (
		calm && ctrl_ff[5:3] == 3'h3 && $changed(dataValidOut)
		|-> ##4 $rose(panelPixelClockOut))
		else $error("shifted panel clock edge misplaced");
endmodule : tpt_timing_gen_assertions
bind tpt_timing_gen tpt_timing_gen_assertions #(.PIX_W(PIX_W)) u_chk (
	.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .lineSyncOut, .frameSyncOut, .dataValidOut,
	.pixelDataOut, .panelPixelClockOut);

// [tpt_panel_model.sv]
`timescale 1ns/1ps
module tpt_panel_model (
	input wire logic pclk,
	input wire logic lineSync,
	input wire logic frameSync,
	input wire logic dataValid,
	input wire logic [23:0] pixData,
	input wire logic lineLow,
	input wire logic frameLow,
	output logic [15:0] linePix,
	output logic [15:0] validPix,
	output logic [15:0] firstVal,
	output logic [15:0] frameLines,
	output logic [15:0] frameVal,
	output logic [15:0] seqErr
);
	logic [15:0] pixCnt, valCnt, lineCnt, fvCnt;
	logic [23:0] lastData;
	logic lsPrev, fsPrev, haveData, ls, fs;
	assign ls = lineSync ^ lineLow;
	assign fs = frameSync ^ frameLow;
	initial begin
		{pixCnt, valCnt, lineCnt, fvCnt, seqErr} = '0;
		{lsPrev, fsPrev, haveData} = 3'h0;
	end
	// The panel samples on the rising edge of its forwarded clock.
	always @(posedge pclk) begin
		lsPrev <= ls;
		fsPrev <= fs;
		if (ls && !lsPrev) begin
			linePix <= pixCnt;
			pixCnt <= 16'h0001;
			valCnt <= 16'h0000;
			if (valCnt != 16'h0000) validPix <= valCnt;
		end else begin
			pixCnt <= pixCnt + 16'h0001;
			valCnt <= valCnt + 16'(dataValid);
			if (dataValid && valCnt == 16'h0000) firstVal <= pixCnt;
		end
		if (fs && !fsPrev) begin
			frameLines <= lineCnt;
			frameVal <= fvCnt;
			lineCnt <= 16'h0001;
			fvCnt <= 16'h0000;
		end else begin
			lineCnt <= lineCnt + 16'(ls && !lsPrev);
			fvCnt <= fvCnt + 16'(dataValid);
		end
		if (dataValid) begin
			if (haveData && pixData != lastData + 24'h00_0001) begin
				seqErr <= seqErr + 16'h0001;
			end
			lastData <= pixData;
			haveData <= 1'b1;
		end
	end
endmodule : tpt_panel_model

// [tb_tpt_timing_gen.sv]
`timescale 1ns/1ps
`include "tpt_params.svh"
module tb_tpt_timing_gen;
	logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, e, pixValid = 0, pixReady, took = 0;
	logic [23:0] pixData = 0, pixOut;
	logic lineSync, frameSync, valid, pclk, lineLow = 0, frameLow = 0;
	logic [15:0] linePix, validPix, firstVal, frameLines, frameVal, seqErr;
	int n_errors = 0;
	int n_tests = 0;
	tpt_timing_gen u_tpt_timing_gen (.ref_clk(ref_clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pixValid(pixValid), .pixReady(pixReady), .pixData(pixData),
		.lineSyncOut(lineSync), .frameSyncOut(frameSync),
		.dataValidOut(valid), .pixelDataOut(pixOut),
		.panelPixelClockOut(pclk));
	tpt_panel_model u_tpt_panel_model (.pclk(pclk), .lineSync(lineSync),
		.frameSync(frameSync), .dataValid(valid), .pixData(pixOut),
		.lineLow(lineLow), .frameLow(frameLow), .linePix(linePix),
		.validPix(validPix), .firstVal(firstVal), .frameLines(frameLines),
		.frameVal(frameVal), .seqErr(seqErr));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// The handshake is judged on values settled before the rising edge.
	always @(negedge ref_clk) took = pixValid && pixReady;
	always @(posedge ref_clk) if (took) pixData <= pixData + 24'h00_0001;
	task automatic complete_run;
		if (n_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] x, y);
		n_tests++;
		if (y !== x) begin
			$display("unexpected %s: expected %h seen %h", nm, x, y);
			n_errors++;
		end
	endtask : chk
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm,
		input logic [31:0] m = 32'hFFFF_FFFF);
		xfer(1'b0, a, 32'h0000_0000);
		chk(nm, x, q & m);
	endtask : rd
	task automatic panelChk;
		chk("line period", 32'h0000_000A, linePix);
		chk("valid per line", 32'h0000_0004, validPix);
		chk("first valid", 32'h0000_0003, firstVal);
		chk("frame lines", 32'h0000_0005, frameLines);
		chk("valid per frame", 32'h0000_0008, frameVal);
	endtask : panelChk
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		rd(8'h00, `TPT_CTRL_RST, "ctrl");
		rd(8'h04, `TPT_SIZE_RST, "size");
		rd(8'h08, `TPT_HPAR_RST, "hpar");
		rd(8'h0C, `TPT_VPAR_RST, "vpar");
		rd(8'h14, 32'h0000_0000, "unmapped");
		chk("slverr", 32'h0000_0001, e);
		xfer(1'b1, 8'h04, 32'h0002_0004);
		xfer(1'b1, 8'h08, 32'h0030_0801);
		xfer(1'b1, 8'h0C, 32'h0010_0401);
		pixValid <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk("ready when full", 32'h0000_0000, pixReady);
		chk("words taken", 32'h0000_0002, pixData);
		xfer(1'b1, 8'h00, 32'h0000_0301);
		repeat (600) @(posedge ref_clk);
		panelChk;
		lineLow <= 1'b1;
		frameLow <= 1'b1;
		xfer(1'b1, 8'h00, 32'h0000_0107);
		repeat (600) @(posedge ref_clk);
		panelChk;
		chk("order", 32'h0000_0000, seqErr);
		xfer(1'b1, 8'h00, 32'h0000_011F);
		repeat (600) @(posedge ref_clk);
		panelChk;
		pixValid <= 1'b0;
		repeat (200) @(posedge ref_clk);
		rd(8'h10, 32'h0000_0001, "underrun", 32'h0000_0001);
		xfer(1'b1, 8'h00, 32'h0000_0100);
		xfer(1'b1, 8'h10, 32'h0000_0001);
		rd(8'h10, 32'h0000_0000, "cleared", 32'h0000_0001);
		complete_run;
	end
	initial begin
		#50000;
		n_errors++;
		complete_run;
	end
endmodule : tb_tpt_timing_gen
